/* nhr_params.svh */
// Timing and encoding constants for the page-read host controller
`ifndef NHR_PARAMS_SVH
`define NHR_PARAMS_SVH
`define NHR_CMD_READ_SETUP 8'h00
`define NHR_CMD_READ_CONFIRM 8'h30
`define NHR_CMD_COL_CHANGE 8'h05
`define NHR_CMD_COL_CONFIRM 8'hE0
`define NHR_ADDR_CYCLES 3'h5
`define NHR_PAGE_BYTES 12'h840
`define NHR_CLK_NS 50
`define NHR_EDO_THRESH_NS 30
`define NHR_STROBE_HALF 4'h1
`endif

/* nhr_pkg.sv */
// Types for the page-read host controller
package nhr_pkg;
    typedef enum logic [3:0] {
        NHR_IDLE = 4'h0,
        NHR_CMD = 4'h1,
        NHR_ADDR = 4'h2,
        NHR_CONF = 4'h3,
        NHR_WAIT = 4'h4,
        NHR_RLOW = 4'h5,
        NHR_RHIGH = 4'h6,
        NHR_DONE = 4'h7
    } nhr_state_t;
    typedef struct packed {
        logic random;
        logic [11:0] column;
        logic [17:0] row;
        logic [11:0] count;
    } nhr_req_t;
    typedef struct packed {
        logic chip_enable_n;
        logic command_latch_sel;
        logic address_latch_sel;
        logic input_strobe_n;
        logic output_strobe_n;
        logic write_protect_n;
    } nhr_pins_t;
endpackage

/* nhr_host.sv */
// Host controller issuing page reads and random column reads to NAND
// Contract
// - Command bytes go with command_latch_sel high, taken on strobe rise.
// - Address bytes go with address_latch_sel high, taken on strobe rise.
// - Host holds write_protect_n low through power-up and power-down.
// - Full address is five cycles: two column, three row.
// - Column cycles carry bits 0-7, then 8-11 with top nibble low.
// - Row cycles carry 12-27 bytewise; fifth holds 28,29, rest low.
// - Bit 29 used in larger part, driven low in smaller part.
// - Page read is setup command, five addresses, confirm, then busy.
// - Host waits for ready before clocking out read data.
// - Short strobe cycles use extended output, capture on next fall; EXTENDED_OUTPUT_MODE is unused, capture is at strobe rise.
// - Column change: command, two column cycles, confirm.
`timescale 1ns/10ps
`default_nettype none
`include "nhr_params.svh"
module nhr_host
    import nhr_pkg::*;
#(
    parameter bit LARGE_DENSITY = 1'b1,
    parameter int CLK_NS = `NHR_CLK_NS
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Request side
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire nhr_req_t req_i,
    input wire logic power_ok_i,
    // Data side
    output logic data_valid_o,
    input wire logic data_ready_i,
    output logic [7:0] data_o,
    output logic busy_o,
    // Flash pins
    output nhr_pins_t pins_o,
    output logic [7:0] bus_o,
    output logic bus_oe_o,
    input wire logic [7:0] bus_i,
    input wire logic ready_busy_n_i
);
    localparam bit EXTENDED_OUTPUT_MODE = CLK_NS < `NHR_EDO_THRESH_NS;

    // ==================================================
    // Address byte mapping
    function automatic logic [7:0] addr_byte(input logic [2:0] idx,
                                            input nhr_req_t r);
        logic [29:0] a;
        a = {r.row, r.column};
        if (!LARGE_DENSITY) begin
            a[29] = 1'b0;
        end
        case (idx)
            3'h0: addr_byte = a[7:0];
            3'h1: addr_byte = {4'h0, a[11:8]};
            3'h2: addr_byte = a[19:12];
            3'h3: addr_byte = a[27:20];
            3'h4: addr_byte = {6'h00, a[29:28]};
            default: addr_byte = 8'h00;
        endcase
    endfunction

    // ==================================================
    // Sequencer
    nhr_state_t state_reg, state_next;
    nhr_req_t req_reg, req_next;
    logic [2:0] idx_reg, idx_next;
    logic [11:0] left_reg, left_next;
    logic phase_reg, phase_next;
    logic conf_reg, conf_next;
    logic [7:0] bus_reg, bus_next;
    logic oe_reg, oe_next;
    nhr_pins_t pins_reg, pins_next;
    logic pend_reg, pend_next;
    logic buf_push, buf_ready;

    always_comb begin
        state_next = state_reg;
        req_next = req_reg;
        idx_next = idx_reg;
        left_next = left_reg;
        phase_next = phase_reg;
        conf_next = conf_reg;
        bus_next = bus_reg;
        oe_next = oe_reg;
        pins_next = pins_reg;
        pend_next = 1'b0;
        pins_next.write_protect_n = power_ok_i;
        case (state_reg)
            NHR_IDLE: begin
                pins_next.chip_enable_n = 1'b1;
                oe_next = 1'b0;
                if (req_valid_i) begin
                    req_next = req_i;
                    state_next = NHR_CMD;
                    phase_next = 1'b0;
                    pins_next.chip_enable_n = 1'b0;
                end
            end
            NHR_CMD: begin
                if (!phase_reg) begin
                    pins_next.command_latch_sel = 1'b1;
                    pins_next.input_strobe_n = 1'b0;
                    oe_next = 1'b1;
                    bus_next = req_reg.random ? `NHR_CMD_COL_CHANGE
                                              : `NHR_CMD_READ_SETUP;
                    phase_next = 1'b1;
                end else begin
                    pins_next.input_strobe_n = 1'b1;
                    phase_next = 1'b0;
                    idx_next = 3'h0;
                    state_next = NHR_ADDR;
                end
            end
            NHR_ADDR: begin
                if (!phase_reg) begin
                    pins_next.command_latch_sel = 1'b0;
                    pins_next.address_latch_sel = 1'b1;
                    pins_next.input_strobe_n = 1'b0;
                    bus_next = addr_byte(idx_reg, req_reg);
                    phase_next = 1'b1;
                end else begin
                    pins_next.input_strobe_n = 1'b1;
                    phase_next = 1'b0;
                    idx_next = idx_reg + 3'h1;
                    // Column change stops after two cycles
                    if ((req_reg.random && idx_reg == 3'h1) ||
                        idx_reg == `NHR_ADDR_CYCLES - 3'h1) begin
                        state_next = NHR_CONF;
                    end
                end
            end
            NHR_CONF: begin
                if (!phase_reg) begin
                    pins_next.address_latch_sel = 1'b0;
                    pins_next.command_latch_sel = 1'b1;
                    pins_next.input_strobe_n = 1'b0;
                    bus_next = req_reg.random ? `NHR_CMD_COL_CONFIRM
                                              : `NHR_CMD_READ_CONFIRM;
                    phase_next = 1'b1;
                end else begin
                    pins_next.input_strobe_n = 1'b1;
                    phase_next = 1'b0;
                    conf_next = 1'b0;
                    state_next = NHR_WAIT;
                end
            end
            NHR_WAIT: begin
                pins_next.command_latch_sel = 1'b0;
                oe_next = 1'b0;
                conf_next = 1'b1;
                left_next = req_reg.count;
                // Skip the stale ready level right after confirm
                if (conf_reg && ready_busy_n_i) begin
                    state_next = (req_reg.count == 12'h000) ? NHR_DONE
                                                           : NHR_RLOW;
                end
            end
            NHR_RLOW: begin
                if (buf_ready) begin
                    pins_next.output_strobe_n = 1'b0;
                    pend_next = 1'b1;
                    state_next = NHR_RHIGH;
                end
            end
            NHR_RHIGH: begin
                pins_next.output_strobe_n = 1'b1;
                left_next = left_reg - 12'h001;
                state_next = (left_reg == 12'h001) ? NHR_DONE : NHR_RLOW;
            end
            NHR_DONE: begin
                pins_next.chip_enable_n = 1'b1;
                state_next = NHR_IDLE;
            end
            default: state_next = NHR_IDLE;
        endcase
    end
    // Byte taken at the edge ending the strobe low phase, before release
    assign buf_push = pend_reg;
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            state_reg <= NHR_IDLE;
            req_reg <= '0;
            idx_reg <= 3'h0;
            left_reg <= 12'h000;
            phase_reg <= 1'b0;
            conf_reg <= 1'b0;
            bus_reg <= 8'h00;
            oe_reg <= 1'b0;
            pins_reg <= 6'h26;
            pend_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            req_reg <= req_next;
            idx_reg <= idx_next;
            left_reg <= left_next;
            phase_reg <= phase_next;
            conf_reg <= conf_next;
            bus_reg <= bus_next;
            oe_reg <= oe_next;
            pins_reg <= pins_next;
            pend_reg <= pend_next;
        end
    end

    // ==================================================
    // Two-entry read buffer
    logic [7:0] mem_reg [2];
    logic [7:0] mem_next [2];
    logic [1:0] cnt_reg, cnt_next;
    logic wp_reg, wp_next, rp_reg, rp_next;
    logic pop;
    assign pop = data_valid_o && data_ready_i;
    // Ready only if the buffer is empty by the next edge; no earlier byte is still in flight in NHR_RLOW
    assign buf_ready = (cnt_reg == 2'h0) || (cnt_reg == 2'h1 && pop);
    always_comb begin
        mem_next = mem_reg;
        wp_next = wp_reg;
        rp_next = rp_reg;
        cnt_next = cnt_reg;
        if (buf_push) begin
            mem_next[wp_reg] = bus_i;
            wp_next = ~wp_reg;
        end
        if (pop) begin
            rp_next = ~rp_reg;
        end
        cnt_next = cnt_reg + {1'b0, buf_push} - {1'b0, pop};
    end
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            mem_reg[0] <= 8'h00;
            mem_reg[1] <= 8'h00;
            cnt_reg <= 2'h0;
            wp_reg <= 1'b0;
            rp_reg <= 1'b0;
        end else begin
            mem_reg <= mem_next;
            cnt_reg <= cnt_next;
            wp_reg <= wp_next;
            rp_reg <= rp_next;
        end
    end
    assign data_valid_o = cnt_reg != 2'h0;
    assign data_o = mem_reg[rp_reg];
    assign req_ready_o = state_reg == NHR_IDLE;
    assign busy_o = state_reg != NHR_IDLE;
    assign pins_o = pins_reg;
    assign bus_o = bus_reg;
    assign bus_oe_o = oe_reg;

    // ==================================================
    // Checks
    sequence s_strobe_low;
        state_reg == NHR_RLOW && buf_ready;
    endsequence

    chk_read_ready: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        $fell(pins_o.output_strobe_n) |-> $past(ready_busy_n_i))
        else $error("read strobe while device busy");
    chk_strobe_push: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        s_strobe_low |-> ##1 buf_push)
        else $error("strobe byte not captured");
    chk_cmd_latch: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        $rose(pins_o.input_strobe_n) && $past(state_reg) == NHR_ADDR
        |-> pins_o.address_latch_sel && !pins_o.command_latch_sel)
        else $error("address strobe without latch select");
    chk_col_high: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        state_reg == NHR_ADDR && idx_reg == 3'h1 && phase_reg
        |-> bus_o[7:4] == 4'h0)
        else $error("column high nibble not low");
    chk_fifth_low: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        state_reg == NHR_ADDR && idx_reg == 3'h4 && phase_reg
        |-> bus_o[7:2] == 6'h00)
        else $error("fifth address cycle upper bits set");
    chk_bus_release: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        !pins_o.output_strobe_n |-> !bus_oe_o)
        else $error("host drives bus during read strobe");
    chk_cmd_sel: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        state_reg == NHR_CONF && phase_reg |-> pins_o.command_latch_sel)
        else $error("confirm without command latch");
    chk_ce_sel: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        state_reg == NHR_CMD |-> !pins_o.chip_enable_n)
        else $error("command sent while deselected");
endmodule
`default_nettype wire

/* nhr_flash_model.sv */
// Behavioural flash device answering the page-read host
`timescale 1ns/10ps
`default_nettype none
module nhr_flash_model
    import nhr_pkg::*;
#(
    parameter int BUSY_CYC = 40,
    parameter bit PROTECT_AT_ON = 1'b0
) (
    // Clock for the internal read latency
    input wire logic clk_i,
    // Host driven pins
    input wire nhr_pins_t pins_i,
    input wire logic [7:0] io_i,
    // Device outputs
    output logic [7:0] io_o,
    output logic ready_busy_n_o
);
    logic [7:0] cyc [0:4];
    logic [7:0] last_cmd;
    logic [11:0] col;
    logic [17:0] row;
    logic [7:0] dout;
    logic locked;
    logic standby;
    int acnt;
    int busy;
    int viol;
    int refused;
    initial begin
        acnt = 0;
        busy = 0;
        viol = 0;
        refused = 0;
        dout = 8'h5A;
        col = 12'h000;
        row = 18'h00000;
        last_cmd = 8'hFF;
        locked = PROTECT_AT_ON;
    end
    // ==========================================
    // Command and address latch
    always @(posedge pins_i.input_strobe_n) begin
        if (!pins_i.chip_enable_n && pins_i.command_latch_sel) begin
            last_cmd = io_i;
            if (io_i == 8'h00 || io_i == 8'h05) begin
                acnt = 0;
            end
            if (io_i == 8'h80 && (!pins_i.write_protect_n || locked)) begin
                refused++;
            end
            if (io_i == 8'h30) begin
                if (acnt != 5) begin
                    viol++;
                end
                row = {cyc[4][1:0], cyc[3], cyc[2]};
                busy = BUSY_CYC;
            end
            if (io_i == 8'hE0 && acnt != 2) begin
                viol++;
            end
            if (io_i == 8'h30 || io_i == 8'hE0) begin
                col = {cyc[1][3:0], cyc[0]};
            end
        end else if (!pins_i.chip_enable_n && pins_i.address_latch_sel) begin
            if (acnt < 5) begin
                cyc[acnt] = io_i;
            end
            acnt++;
        end
    end
    // ==========================================
    // Latency runs on whatever chip enable does
    always @(posedge clk_i) begin
        if (busy > 0) begin
            busy--;
        end
    end
    // ==========================================
    // Data out from the page buffer
    always @(negedge pins_i.output_strobe_n) begin
        if (!pins_i.chip_enable_n) begin
            if (busy != 0 || col >= 12'h840) begin
                viol++;
            end
            dout = (col[7:0] + {4'h0, col[11:8]}) ^ row[7:0];
            col = col + 12'h001;
        end
    end
    assign standby = pins_i.chip_enable_n && busy == 0;
    // Released bus shows the inverse, never the held byte
    assign io_o = (!pins_i.chip_enable_n && !pins_i.output_strobe_n) ?
        dout : ~dout;
    assign ready_busy_n_o = (busy == 0);
endmodule
`default_nettype wire

/* nand_host_bus_page_read_tb_top.sv */
// Self-checking bench for the page-read host controller
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
    $display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end
module nand_host_bus_page_read_tb_top;
    import nhr_pkg::*;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic req_valid_i = 1'b0;
    logic req_ready_o, power_ok_i = 1'b0, data_ready_i = 1'b0;
    logic data_valid_o, busy_o, bus_oe_o, rb_n;
    logic [7:0] data_o, bus_o, dev_io;
    wire [7:0] io_w;
    nhr_req_t req_i = '0;
    nhr_pins_t pins_o;
    int error_cnt = 0;
    int checked = 0;
    int cycles = 0;
    logic [17:0] cur_row;
    assign io_w = bus_oe_o ? bus_o : dev_io;
    nhr_host dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_i(req_i),
        .power_ok_i(power_ok_i), .data_valid_o(data_valid_o),
        .data_ready_i(data_ready_i), .data_o(data_o), .busy_o(busy_o),
        .pins_o(pins_o), .bus_o(bus_o), .bus_oe_o(bus_oe_o), .bus_i(io_w),
        .ready_busy_n_i(rb_n));
    nhr_flash_model mod_u (.clk_i(clk_i), .pins_i(pins_o), .io_i(io_w),
        .io_o(dev_io), .ready_busy_n_o(rb_n));
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            print_verdict();
        end
    end
    function automatic logic [7:0] exp_byte(logic [17:0] r, logic [11:0] c);
        return (c[7:0] + {4'h0, c[11:8]}) ^ r[7:0];
    endfunction
    // ==========================================
    // One read request, receiver stalls for the first cycles
    task automatic do_read(logic rnd, logic [11:0] c, logic [17:0] r,
                           logic [11:0] n, int stall);
        int i;
        int k;
        i = 0;
        k = 0;
        @(negedge clk_i);
        req_i = '{random: rnd, column: c, row: r, count: n};
        req_valid_i = 1'b1;
        while (req_ready_o !== 1'b1 && k < 100) begin
            @(negedge clk_i);
            k++;
        end
        @(negedge clk_i);
        req_valid_i = 1'b0;
        k = 0;
        while (busy_o !== 1'b0 && k < 3000) begin
            data_ready_i = (k >= stall);
            if (data_valid_o === 1'b1 && data_ready_i) begin
                `CHK(data_o, exp_byte(cur_row, c + 12'(i)))
                i++;
            end
            @(negedge clk_i);
            k++;
        end
        data_ready_i = 1'b0;
        `CHK(i, int'(n))
        `CHK(data_valid_o, 1'b0)
        `CHK(pins_o.chip_enable_n, 1'b1)
        `CHK(mod_u.standby, 1'b1)
        `CHK(mod_u.viol, 0)
    endtask
    task automatic s_page_read();
        cur_row = 18'h24041;
        do_read(1'b0, 12'h7FE, cur_row, 12'h006, 80);
        `CHK(mod_u.last_cmd, 8'h30)
        `CHK(mod_u.row, cur_row)
        `CHK(mod_u.cyc[0], 8'hFE)
        `CHK(mod_u.cyc[1], 8'h07)
        `CHK(mod_u.cyc[2], 8'h41)
        `CHK(mod_u.cyc[4], 8'h02)
    endtask
    task automatic s_random_col();
        do_read(1'b1, 12'h83C, cur_row, 12'h004, 0);
        `CHK(mod_u.last_cmd, 8'hE0)
        `CHK(mod_u.acnt, 2)
        `CHK(mod_u.col, 12'h840)
    endtask
    task automatic s_zero_count();
        cur_row = 18'h00123;
        do_read(1'b0, 12'h010, cur_row, 12'h000, 0);
        `CHK(mod_u.row, cur_row)
    endtask
    task automatic s_power_wp();
        `CHK(pins_o.write_protect_n, 1'b0)
        @(negedge clk_i);
        power_ok_i = 1'b1;
        @(negedge clk_i);
        @(negedge clk_i);
        `CHK(pins_o.write_protect_n, 1'b1)
    endtask
    task automatic s_power_down();
        @(negedge clk_i);
        power_ok_i = 1'b0;
        @(negedge clk_i);
        `CHK(pins_o.write_protect_n, 1'b0)
    endtask
    task automatic print_verdict();
        if (error_cnt == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(negedge clk_i);
        `CHK(pins_o.chip_enable_n, 1'b1)
        rst_b_i = 1'b1;
        s_power_wp();
        s_page_read();
        s_random_col();
        s_zero_count();
        s_page_read();
        s_power_down();
        print_verdict();
    end
endmodule
`default_nettype wire
